// ### verilog/hoda_top.sv
// heater open detect alarm: wishbone registers, two channels, interrupt
//
// How it works
// - evaluate only while heating output is on
// - cooling-assigned channel never raises the alarm
// - current below threshold during on time alarms
// - on intervals of 100 ms or less skipped
// - threshold 0.0 forces off, 100.0 forces on except on a cooling-assigned channel
// - thresholds 0.1 to 99.9 A compare normally
// - per-channel hysteresis 0.1 to 100.0, default 0.1
// - alarm never alters the control output
// - latched alarm holds after current recovers
// - error clear, soft reset, threshold 0.0 release
// - latch enable per channel, reset value 0
// - readable current monitor per channel, 0-110 A
`timescale 1ns/1ns
`default_nettype none
module hoda_top
  import hoda_pkg::*;
#(
  parameter int ON_SKIP_CYC_P = ON_SKIP_CYC
) (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // heating output levels, asynchronous pins
  input wire logic [1:0] HEAT_ON_IN,
  // current front end, same clock
  input wire logic [10:0] CURRENT_SENSE_INPUT_1_IN,
  input wire logic [10:0] CURRENT_SENSE_INPUT_2_IN,
  input wire logic [1:0] CUR_VALID_IN,
  // alarms and interrupt
  output logic [1:0] HEATER_OPEN_ALARM_OUT,
  output logic IRQ_OUT
);
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic ack;
    logic [31:0] rdat;
    logic run;
    logic [1:0] cooling;
    logic [1:0][10:0] thr;
    logic [1:0][10:0] hys;
    logic [1:0] latch_en;
    logic clear;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [1:0] alarm;
    logic irq;
  } hoda_top_st_t;

  localparam hoda_top_st_t ST_RST = '{
    sync1: 2'h0,
    sync2: 2'h0,
    ack: 1'b0,
    rdat: 32'h0,
    run: 1'b0,
    cooling: 2'h0,
    thr: {THR_RST, THR_RST},
    hys: {HYS_RST, HYS_RST},
    latch_en: 2'h0,
    clear: 1'b0,
    irq_stat: IRQ_STAT_RST,
    irq_mask: IRQ_MASK_RST,
    alarm: 2'h0,
    irq: 1'b0
  };

  hoda_top_st_t s_ff;
  hoda_top_st_t nxt_s;
  logic [1:0] alarm_w;
  logic [1:0][10:0] mon_w;
  logic [1:0][10:0] cur_w;

  assign cur_w[0] = CURRENT_SENSE_INPUT_1_IN;
  assign cur_w[1] = CURRENT_SENSE_INPUT_2_IN;

  hoda_chan_if ch_if[2] ();

  // two identical channels
  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign ch_if[g].thr = s_ff.thr[g];
    assign ch_if[g].hys = s_ff.hys[g];
    assign ch_if[g].latch_en = s_ff.latch_en[g];
    assign ch_if[g].cooling = s_ff.cooling[g];
    assign ch_if[g].clear = s_ff.clear;
    assign alarm_w[g] = ch_if[g].alarm;
    assign mon_w[g] = ch_if[g].mon;
    hoda_chan #(
      .ON_SKIP_CYC_P(ON_SKIP_CYC_P)
    ) u_chan (
      .clk_in(CLK_SYS_IN),
      .rstn_in(RSTN_IN),
      .heat_on_in(s_ff.sync2[g]),
      .cur_in(cur_w[g]),
      .cur_valid_in(CUR_VALID_IN[g]),
      .ch(ch_if[g])
    );
  end

  // merge write data into an old value under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  logic take;
  logic [7:0] adr;
  logic [31:0] old;
  logic [31:0] wd;
  logic [IRQ_W-1:0] ev;
  logic [1:0] idx;

  always_comb begin
    nxt_s = s_ff;
    take = WB_CYC_IN && WB_STB_IN && !s_ff.ack;
    adr = {WB_ADR_IN[7:2], 2'b00};
    idx = 2'h0;
    old = 32'h0;
    nxt_s.sync1 = HEAT_ON_IN;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.ack = take;
    nxt_s.clear = 1'b0;
    nxt_s.alarm = alarm_w;
    ev = {s_ff.alarm & ~alarm_w, ~s_ff.alarm & alarm_w};
    // read data of the addressed register
    case (adr)
      ADR_CTRL: old = {22'h0, s_ff.cooling, 5'h0, 2'b00, s_ff.run};
      ADR_STATUS: old = {29'h0, s_ff.run, s_ff.alarm};
      ADR_THR1: old = {21'h0, s_ff.thr[0]};
      ADR_THR2: old = {21'h0, s_ff.thr[1]};
      ADR_HYS1: old = {21'h0, s_ff.hys[0]};
      ADR_HYS2: old = {21'h0, s_ff.hys[1]};
      ADR_LATCH: old = {30'h0, s_ff.latch_en};
      ADR_MON1: old = {21'h0, mon_w[0]};
      ADR_MON2: old = {21'h0, mon_w[1]};
      ADR_IRQ_STAT: old = {28'h0, s_ff.irq_stat};
      ADR_IRQ_MASK: old = {28'h0, s_ff.irq_mask};
      default: old = 32'h0;
    endcase
    wd = merge(old, WB_DAT_IN, WB_SEL_IN);
    if (take) begin
      nxt_s.rdat = WB_WE_IN ? 32'h0 : old;
    end
    if (take && !WB_WE_IN && adr == ADR_IRQ_STAT) begin
      nxt_s.irq_stat = '0;
    end
    if (take && WB_WE_IN) begin
      case (adr)
        ADR_CTRL: begin
          nxt_s.run = wd[CTRL_RUN_BIT];
          if (!s_ff.run) begin
            nxt_s.cooling = wd[CTRL_COOL_LSB +: 2];
          end
          if (wd[CTRL_ERR_CLR_BIT]) begin
            nxt_s.clear = 1'b1;
          end
          if (wd[CTRL_SW_RST_BIT]) begin
            nxt_s.clear = 1'b1;
            nxt_s.run = 1'b0;
            nxt_s.irq_stat = '0;
          end
        end
        ADR_THR1, ADR_THR2: begin
          idx = (adr == ADR_THR2) ? 2'h1 : 2'h0;
          if (wd[31:11] == 21'h0 && wd[10:0] <= THR_FORCE_ON) begin
            nxt_s.thr[idx[0]] = wd[10:0];
          end
        end
        ADR_HYS1, ADR_HYS2: begin
          idx = (adr == ADR_HYS2) ? 2'h1 : 2'h0;
          if (!s_ff.run && wd[31:11] == 21'h0 && wd[10:0] >= HYS_MIN
              && wd[10:0] <= HYS_MAX) begin
            nxt_s.hys[idx[0]] = wd[10:0];
          end
        end
        ADR_LATCH: begin
          if (!s_ff.run) begin
            nxt_s.latch_en = wd[1:0];
          end
        end
        ADR_IRQ_MASK: nxt_s.irq_mask = wd[IRQ_W-1:0];
        default: nxt_s.run = nxt_s.run;
      endcase
    end
    // a new event wins over a clear in the same cycle
    nxt_s.irq_stat = nxt_s.irq_stat | ev;
    nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
  end

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      s_ff <= ST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign WB_ACK_OUT = s_ff.ack;
  assign WB_DAT_OUT = s_ff.rdat;
  assign HEATER_OPEN_ALARM_OUT = s_ff.alarm;
  assign IRQ_OUT = s_ff.irq;
endmodule
`default_nettype wire

// ### verilog/hoda_pkg.sv
// constants for the heater open detect alarm block
package hoda_pkg;
  // current values in tenths of an ampere
  localparam int CUR_W = 11;
  localparam logic [10:0] THR_OFF = 11'h000;
  localparam logic [10:0] THR_FORCE_ON = 11'h3E8;
  localparam logic [10:0] THR_RST = 11'h000;
  localparam logic [10:0] HYS_MIN = 11'h001;
  localparam logic [10:0] HYS_MAX = 11'h3E8;
  localparam logic [10:0] HYS_RST = 11'h001;
  localparam logic [10:0] MON_MAX = 11'h44C;
  // longest heating on time that is still skipped
  localparam int CLK_HZ = 100000000;
  localparam int ON_SKIP_MS = 100;
  localparam int ON_SKIP_CYC = ON_SKIP_MS * (CLK_HZ / 1000);
  localparam int ON_CNT_W = 24;
  // register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_THR1 = 8'h08;
  localparam logic [7:0] ADR_THR2 = 8'h0C;
  localparam logic [7:0] ADR_HYS1 = 8'h10;
  localparam logic [7:0] ADR_HYS2 = 8'h14;
  localparam logic [7:0] ADR_LATCH = 8'h18;
  localparam logic [7:0] ADR_MON1 = 8'h1C;
  localparam logic [7:0] ADR_MON2 = 8'h20;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h28;
  // control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_ERR_CLR_BIT = 1;
  localparam int CTRL_SW_RST_BIT = 2;
  localparam int CTRL_COOL_LSB = 8;
  // interrupt status: alarm rise in 1:0, alarm fall in 3:2
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_STAT_RST = 4'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
endpackage

// ### verilog/hoda_chan_if.sv
// settings and state passed between the top and one channel
`timescale 1ns/1ns
`default_nettype none
interface hoda_chan_if;
  logic [10:0] thr;
  logic [10:0] hys;
  logic latch_en;
  logic cooling;
  logic clear;
  logic alarm;
  logic [10:0] mon;
  modport top (output thr, output hys, output latch_en, output cooling, output clear,
    input alarm, input mon);
  modport chan (input thr, input hys, input latch_en, input cooling, input clear,
    output alarm, output mon);
endinterface
`default_nettype wire

// ### verilog/hoda_chan.sv
// one heater open detect channel: on time gate, compare, hysteresis, latch
`timescale 1ns/1ns
`default_nettype none
module hoda_chan
  import hoda_pkg::*;
#(
  parameter int ON_SKIP_CYC_P = ON_SKIP_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // heating output level and measured current
  input wire logic heat_on_in,
  input wire logic [10:0] cur_in,
  input wire logic cur_valid_in,
  // settings and state
  hoda_chan_if.chan ch
);
  typedef struct packed {
    logic [ON_CNT_W-1:0] on_cnt;
    logic alarm;
    logic [10:0] mon;
  } hoda_chan_st_t;

  localparam logic [ON_CNT_W-1:0] SKIP = ON_CNT_W'(ON_SKIP_CYC_P);

  hoda_chan_st_t s_ff;
  hoda_chan_st_t nxt_s;
  logic eval;
  logic [11:0] release_lvl;

  always_comb begin
    nxt_s = s_ff;
    release_lvl = {1'b0, ch.thr} + {1'b0, ch.hys};
    // evaluate only after the on time has passed the skip time
    eval = heat_on_in && (s_ff.on_cnt >= SKIP) && cur_valid_in;
    if (!heat_on_in) begin
      nxt_s.on_cnt = '0;
    end else if (s_ff.on_cnt < SKIP) begin
      nxt_s.on_cnt = s_ff.on_cnt + 1'b1;
    end
    if (cur_valid_in) begin
      nxt_s.mon = (cur_in > MON_MAX) ? MON_MAX : cur_in;
    end
    if (ch.cooling) begin
      nxt_s.alarm = 1'b0;
    end else if (ch.thr == THR_OFF) begin
      nxt_s.alarm = 1'b0;
    end else if (ch.thr >= THR_FORCE_ON) begin
      nxt_s.alarm = 1'b1;
    end else if (ch.clear) begin
      nxt_s.alarm = 1'b0;
    end else if (eval) begin
      if (cur_in < ch.thr) begin
        nxt_s.alarm = 1'b1;
      end else if (!(s_ff.alarm && ch.latch_en) && ({1'b0, cur_in} >= release_lvl)) begin
        nxt_s.alarm = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign ch.alarm = s_ff.alarm;
  assign ch.mon = s_ff.mon;
endmodule
`default_nettype wire

// ### test/hoda_top_checker.sv
// port checks for the heater open detect alarm top
`timescale 1ns/1ns
`default_nettype none
module hoda_top_checker
  import hoda_pkg::*;
#(
  parameter int ON_SKIP_CYC_P = ON_SKIP_CYC
) (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  // wishbone
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // heating and current
  input wire logic [1:0] HEAT_ON_IN,
  input wire logic [10:0] CURRENT_SENSE_INPUT_1_IN,
  input wire logic [10:0] CURRENT_SENSE_INPUT_2_IN,
  input wire logic [1:0] CUR_VALID_IN,
  // alarms and interrupt
  input wire logic [1:0] HEATER_OPEN_ALARM_OUT,
  input wire logic IRQ_OUT
);
  wire take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  wire wr = take && WB_WE_IN;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);
  ack_one_cycle_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack held");
  ack_latency_a: assert property (take |=> WB_ACK_OUT) else $error("ack late");
  ack_cause_a: assert property ($rose(WB_ACK_OUT) |-> $past(take)) else $error("stray ack");
  write_rdata_zero_a: assert property (WB_ACK_OUT && $past(WB_WE_IN) |-> WB_DAT_OUT == 32'h0)
    else $error("write data not 0");
  mon_range_a: assert property (
    WB_ACK_OUT && !$past(WB_WE_IN) && $past(WB_ADR_IN) == ADR_MON1
    |-> WB_DAT_OUT <= {21'h0, MON_MAX}) else $error("monitor range");
  // a write reaches the pins one cycle later than a current sample
  alarm_cause_a: assert property ($changed(HEATER_OPEN_ALARM_OUT) |->
    $past(CUR_VALID_IN != 2'b00, 2) || $past(wr, 3)) else $error("alarm moved uncaused");
  irq_rise_cause_a: assert property ($rose(IRQ_OUT) |->
    $changed(HEATER_OPEN_ALARM_OUT) || $past(wr) || $past(wr, 2)) else $error("irq rose");
  irq_fall_cause_a: assert property ($fell(IRQ_OUT) |-> $past(take) || $past(take, 2))
    else $error("irq fell");
  cover property ($rose(HEATER_OPEN_ALARM_OUT[0]));
  cover property ($fell(HEATER_OPEN_ALARM_OUT[1]));
  cover property ($rose(IRQ_OUT));
endmodule
`default_nettype wire

// ### test/hoda_top_tb.sv
// testbench for the heater open detect alarm top
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, e); end end
module hoda_top_tb;
  import hoda_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [1:0] heat = 2'b00, vld = 2'b00, alm;
  logic [10:0] cur1 = 11'h000, cur2 = 11'h000;
  int fails = 0, n_checks = 0, n_cyc = 0;
  hoda_top #(.ON_SKIP_CYC_P(20)) u_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(dat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .HEAT_ON_IN(heat), .CURRENT_SENSE_INPUT_1_IN(cur1),
    .CURRENT_SENSE_INPUT_2_IN(cur2), .CUR_VALID_IN(vld), .HEATER_OPEN_ALARM_OUT(alm),
    .IRQ_OUT(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 3000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic chk_al(input logic [1:0] e);
    repeat (3) @(posedge clk);
    `CHK(alm, e)
  endtask
  // one current sample on the channels in m
  task automatic smp(input logic [1:0] m, input logic [10:0] c, input logic [1:0] e);
    @(posedge clk);
    vld <= m;
    cur1 <= c;
    cur2 <= c;
    @(posedge clk);
    vld <= 2'b00;
    chk_al(e);
  endtask
  task automatic set_heat(input logic [1:0] h, input int n);
    @(posedge clk);
    heat <= h;
    repeat (n) @(posedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(ADR_THR1, 32'h0);
    rd(ADR_HYS2, 32'h1);
    rd(ADR_LATCH, 32'h0);
    rd(8'h3C, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b1, ADR_HYS1, 32'hA);
    rd(ADR_HYS1, 32'h1);
    wb(1'b1, ADR_CTRL, 32'h0);
    wb(1'b1, ADR_HYS1, 32'hA);
    wb(1'b1, ADR_THR1, 32'h32);
    wb(1'b1, ADR_IRQ_MASK, 32'hF);
    set_heat(2'b11, 5);
    smp(2'b01, 11'h028, 2'b00);
    repeat (25) @(posedge clk);
    smp(2'b01, 11'h028, 2'b01);
    `CHK(irq, 1'b1)
    rd(ADR_IRQ_STAT, 32'h1);
    rd(ADR_IRQ_STAT, 32'h0);
    `CHK(irq, 1'b0)
    smp(2'b01, 11'h037, 2'b01);
    smp(2'b01, 11'h03C, 2'b00);
    rd(ADR_IRQ_STAT, 32'h4);
    wb(1'b1, ADR_THR2, 32'h1E);
    smp(2'b10, 11'h014, 2'b10);
    wb(1'b1, ADR_THR2, 32'h0);
    set_heat(2'b00, 5);
    smp(2'b01, 11'h00A, 2'b00);
    wb(1'b1, ADR_LATCH, 32'h1);
    set_heat(2'b11, 30);
    smp(2'b01, 11'h028, 2'b01);
    smp(2'b01, 11'h046, 2'b01);
    wb(1'b1, ADR_CTRL, 32'h2);
    chk_al(2'b00);
    smp(2'b01, 11'h028, 2'b01);
    wb(1'b1, ADR_CTRL, 32'h4);
    chk_al(2'b00);
    smp(2'b01, 11'h028, 2'b01);
    wb(1'b1, ADR_THR1, 32'h0);
    chk_al(2'b00);
    wb(1'b1, ADR_THR1, 32'h3E8);
    chk_al(2'b01);
    wb(1'b1, ADR_THR1, 32'h3E9);
    rd(ADR_THR1, 32'h3E8);
    wb(1'b1, ADR_THR1, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h200);
    wb(1'b1, ADR_THR2, 32'h3E8);
    chk_al(2'b00);
    smp(2'b01, 11'h4B0, 2'b00);
    rd(ADR_MON1, 32'h44C);
    wb(1'b1, ADR_CTRL, 32'h201);
    rd(ADR_CTRL, 32'h201);
    wb(1'b1, ADR_THR1, 32'h3E8);
    chk_al(2'b01);
    rd(ADR_STATUS, 32'h5);
    finish_test();
  end
endmodule
bind hoda_top hoda_top_checker #(.ON_SKIP_CYC_P(ON_SKIP_CYC_P)) u_chk (.CLK_SYS_IN(CLK_SYS_IN),
  .RSTN_IN(RSTN_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN),
  .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT),
  .WB_ACK_OUT(WB_ACK_OUT), .HEAT_ON_IN(HEAT_ON_IN), .CUR_VALID_IN(CUR_VALID_IN),
  .CURRENT_SENSE_INPUT_1_IN(CURRENT_SENSE_INPUT_1_IN), .IRQ_OUT(IRQ_OUT),
  .CURRENT_SENSE_INPUT_2_IN(CURRENT_SENSE_INPUT_2_IN),
  .HEATER_OPEN_ALARM_OUT(HEATER_OPEN_ALARM_OUT));
`default_nettype wire
